//--- rtl/cie_pkg.sv
/*
 cie_pkg: register offsets, opcodes, status layout and bus codes for the
 instruction execution slice.
 assumes: used by cie_exec and cie_exec_tb, every use written cie_pkg::name.
*/
package cie_pkg;
	// register byte offsets on the register bus
	localparam int unsigned ADDR_W = 5;
	localparam logic [4:0] OFF_INSTR = 5'h00;
	localparam logic [4:0] OFF_ACC = 5'h04;
	localparam logic [4:0] OFF_FREG = 5'h08;
	localparam logic [4:0] OFF_STAT = 5'h0c;
	localparam logic [4:0] OFF_STACK = 5'h10;
	localparam logic [4:0] OFF_PC = 5'h14;
	localparam logic [4:0] OFF_WDOG = 5'h18;
	localparam logic [1:0] WORD_LSB = 2'h0;

	// instruction opcodes in the instruction register
	localparam logic [2:0] OP_SLEEP = 3'h0;
	localparam logic [2:0] OP_RET = 3'h1;
	localparam logic [2:0] OP_RROT = 3'h2;
	localparam logic [2:0] OP_LSUB = 3'h3;
	localparam logic [2:0] OP_RSUB = 3'h4;
	localparam logic [2:0] OP_NSWP = 3'h5;
	localparam logic [2:0] OP_RXOR = 3'h6;
	localparam logic [2:0] OP_LXOR = 3'h7;

	// destination select values
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_REG = 1'b1;

	// bits 2:0 op, bit 3 dest, bits 11:4 literal
	typedef struct packed {
		logic [7:0] lit;
		logic dest;
		logic [2:0] op;
	} cie_instr_s;
	localparam int unsigned INSTR_W = $bits(cie_instr_s);

	// bit 0 carry, 1 nibble out, 2 zero, 3 expiry, 4 sleep entry
	typedef struct packed {
		logic sleep_entry_flag;
		logic expiry_flag;
		logic z;
		logic nibble_out_flag;
		logic c;
	} cie_stat_s;
	localparam int unsigned STAT_W = $bits(cie_stat_s);
	localparam logic [4:0] STAT_RST = 5'h18;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] WDOG_CLR = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/cie_exec.sv
/*
 cie_exec: execution slice of an 8-bit core (sleep, subroutine exit,
 rotate right, two subtracts, nibble exchange, two exclusive-ors) with an
 AXI4-Lite register slave; a write to the instruction register issues one when idle and is refused while busy.
 assumes: single 250 MHz clock, bus master keeps AXI4-Lite rules,
 wake_pin is asynchronous and ends the sleep state.
*/
// Operation
// RULE1 - sleep clears sleep entry, sets expiry flag
// RULE2 - sleep zeroes watchdog count and prescaler
// RULE3 - sleep enters low-power state, oscillator halted
// RULE4 - return pops stack head into pc
// RULE5 - return takes two instruction cycles
// RULE6 - rotate right through carry, carry only
// RULE7 - dest bit 0 accumulator, 1 register
// RULE8 - literal minus accumulator into accumulator, flags
// RULE9 - register minus accumulator to destination, flags
// RULE10 - nibble exchange to destination, no flags
// RULE11 - register xor to destination, zero only
// RULE12 - literal xor into accumulator, zero only
// RULE13 - subtract carry flags mean no borrow
// RULE14 - zero flag set when result zero
`timescale 1ns/1ns
module cie_exec #(
	parameter int unsigned STACK_DEPTH = 8,
	parameter int unsigned PC_W = 13
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wake_pin,
	output logic osc_halt,
	input wire logic awvalid,
	output logic awready,
	input wire logic [cie_pkg::ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [cie_pkg::ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	localparam int unsigned SP_W = $clog2(STACK_DEPTH);

	// refused at elaboration: the stack pointer wraps by width, the pc must fit the read word
	if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH || PC_W > 16)
	begin : g_bad_param
		$error("cie_exec: bad stack depth or pc width");
	end

	typedef enum logic [1:0] {cie_idle, cie_ret2, cie_asleep} cie_state_e;

	logic rst_q1, rst_s_n, wake_q1, wake_s;
	cie_state_e state_reg;
	logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [cie_pkg::ADDR_W-1:0] waddr_reg;
	logic [31:0] wdata_reg, rdata_reg, wbe;
	logic [3:0] wstrb_reg;
	logic [7:0] acc_reg, freg_reg, wd_cnt_reg, wd_pre_reg;
	cie_pkg::cie_stat_s stat_reg;
	logic [PC_W-1:0] pc_reg, head;
	logic [PC_W-1:0] stack_mem [STACK_DEPTH];
	logic [SP_W-1:0] sp_reg;
	logic halt_reg;

	// reset release and wake pin synchronisers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_q1 <= 1'b0;
			rst_s_n <= 1'b0;
		end
		else
		begin
			rst_q1 <= 1'b1;
			rst_s_n <= rst_q1;
		end
	end

	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			wake_q1 <= 1'b0;
			wake_s <= 1'b0;
		end
		else
		begin
			wake_q1 <= wake_pin;
			wake_s <= wake_q1;
		end
	end

	// bus write side: address and data held separately, either order
	logic [cie_pkg::ADDR_W-1:0] wa;
	logic wr_do, busy, exec_go, wr_err;
	cie_pkg::cie_instr_s ins;

	assign awready = !aw_held_reg && !bvalid_reg;
	assign wready = !w_held_reg && !bvalid_reg;
	assign wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wa = {waddr_reg[cie_pkg::ADDR_W-1:2], cie_pkg::WORD_LSB};
	assign busy = state_reg != cie_idle;
	assign ins = cie_pkg::cie_instr_s'(wdata_reg[cie_pkg::INSTR_W-1:0]);
	assign exec_go = wr_do && wa == cie_pkg::OFF_INSTR && !busy;
	assign wr_err = !(wa inside {cie_pkg::OFF_INSTR, cie_pkg::OFF_ACC, cie_pkg::OFF_FREG,
		cie_pkg::OFF_STAT, cie_pkg::OFF_STACK, cie_pkg::OFF_PC, cie_pkg::OFF_WDOG})
		|| (wa == cie_pkg::OFF_INSTR && busy);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_be
			assign wbe[gi*8 +: 8] = {8{wstrb_reg[gi]}};
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= cie_pkg::RESP_OKAY;
			waddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held_reg <= 1'b1;
				waddr_reg <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held_reg <= 1'b1;
				wdata_reg <= wdata;
				wstrb_reg <= wstrb;
			end
			if (wr_do)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_err ? cie_pkg::RESP_SLVERR : cie_pkg::RESP_OKAY;
			end
			else if (bvalid_reg && bready)
				bvalid_reg <= 1'b0;
		end
	end
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;

	// datapath: source operand, subtract with inverted borrow, results
	logic is_lit, to_acc, to_reg;
	logic [7:0] src, res;
	logic [8:0] diff;
	logic [4:0] ndiff;
	logic c_n, dc_n, wr_c, wr_dc, wr_z;

	always_comb
	begin
		is_lit = ins.op == cie_pkg::OP_LSUB || ins.op == cie_pkg::OP_LXOR;
		src = is_lit ? ins.lit : freg_reg;
		diff = {1'b0, src} + {1'b0, ~acc_reg} + 9'h001; // [RULE13]
		ndiff = {1'b0, src[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01; // [RULE13]
		res = cie_pkg::BYTE_ZERO;
		c_n = stat_reg.c;
		dc_n = ndiff[4];
		wr_c = 1'b0;
		wr_dc = 1'b0;
		wr_z = 1'b0;
		unique case (ins.op)
			cie_pkg::OP_RROT:
			begin
				res = {stat_reg.c, freg_reg[7:1]}; // [RULE6]
				c_n = freg_reg[0];
				wr_c = 1'b1;
			end
			cie_pkg::OP_LSUB, cie_pkg::OP_RSUB:
			begin
				res = diff[7:0]; // [RULE8] [RULE9]
				c_n = diff[8];
				wr_c = 1'b1;
				wr_dc = 1'b1;
				wr_z = 1'b1;
			end
			cie_pkg::OP_NSWP: res = {freg_reg[3:0], freg_reg[7:4]}; // [RULE10]
			cie_pkg::OP_RXOR, cie_pkg::OP_LXOR:
			begin
				res = acc_reg ^ src; // [RULE11] [RULE12]
				wr_z = 1'b1;
			end
			cie_pkg::OP_SLEEP, cie_pkg::OP_RET: res = cie_pkg::BYTE_ZERO;
		endcase
		// sleep and return write no data; literal forms always land in acc
		to_acc = !(ins.op == cie_pkg::OP_SLEEP || ins.op == cie_pkg::OP_RET)
			&& (is_lit || ins.dest == cie_pkg::DEST_ACC); // [RULE7]
		to_reg = !(ins.op == cie_pkg::OP_SLEEP || ins.op == cie_pkg::OP_RET)
			&& !is_lit && ins.dest == cie_pkg::DEST_REG; // [RULE7]
	end

	// accumulator and operand register: bus writes or results
	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			acc_reg <= cie_pkg::BYTE_ZERO;
			freg_reg <= cie_pkg::BYTE_ZERO;
		end
		else if (exec_go)
		begin
			if (to_acc)
				acc_reg <= res; // [RULE7]
			if (to_reg)
				freg_reg <= res; // [RULE7]
		end
		else if (wr_do && wa == cie_pkg::OFF_ACC)
			acc_reg <= (acc_reg & ~wbe[7:0]) | (wdata_reg[7:0] & wbe[7:0]);
		else if (wr_do && wa == cie_pkg::OFF_FREG)
			freg_reg <= (freg_reg & ~wbe[7:0]) | (wdata_reg[7:0] & wbe[7:0]);
	end

	// status flags
	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
			stat_reg <= cie_pkg::cie_stat_s'(cie_pkg::STAT_RST);
		else if (exec_go)
		begin
			if (ins.op == cie_pkg::OP_SLEEP)
			begin
				stat_reg.sleep_entry_flag <= 1'b0; // [RULE1]
				stat_reg.expiry_flag <= 1'b1; // [RULE1]
			end
			if (wr_c)
				stat_reg.c <= c_n; // [RULE6] [RULE13]
			if (wr_dc)
				stat_reg.nibble_out_flag <= dc_n; // [RULE13]
			if (wr_z)
				stat_reg.z <= res == cie_pkg::BYTE_ZERO; // [RULE14]
		end
		else if (wr_do && wa == cie_pkg::OFF_STAT && wstrb_reg[0])
			stat_reg <= cie_pkg::cie_stat_s'(wdata_reg[cie_pkg::STAT_W-1:0]);
	end

	// watchdog: prescaler wrap is the count enable; runs in sleep too
	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			wd_pre_reg <= cie_pkg::WDOG_CLR;
			wd_cnt_reg <= cie_pkg::WDOG_CLR;
		end
		else if (exec_go && ins.op == cie_pkg::OP_SLEEP)
		begin
			wd_pre_reg <= cie_pkg::WDOG_CLR; // [RULE2]
			wd_cnt_reg <= cie_pkg::WDOG_CLR; // [RULE2]
		end
		else
		begin
			wd_pre_reg <= wd_pre_reg + 8'h01;
			if (&wd_pre_reg)
				wd_cnt_reg <= wd_cnt_reg + 8'h01;
		end
	end

	// return stack is circular like the core's: no overflow error
	assign head = stack_mem[sp_reg - SP_W'(1)];

	always_ff @(posedge clk)
	begin
		if (wr_do && wa == cie_pkg::OFF_STACK)
			stack_mem[sp_reg] <= wdata_reg[PC_W-1:0];
	end

	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			sp_reg <= '0;
			pc_reg <= '0;
		end
		else if (exec_go && ins.op == cie_pkg::OP_RET)
		begin
			sp_reg <= sp_reg - SP_W'(1); // [RULE4]
			pc_reg <= head; // [RULE4]
		end
		else if (wr_do && wa == cie_pkg::OFF_STACK)
			sp_reg <= sp_reg + SP_W'(1);
	end

	// sequencer: second return cycle, and sleep until wake pin
	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			state_reg <= cie_idle;
			halt_reg <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				cie_idle:
					if (exec_go && ins.op == cie_pkg::OP_RET)
						state_reg <= cie_ret2; // [RULE5]
					else if (exec_go && ins.op == cie_pkg::OP_SLEEP)
					begin
						state_reg <= cie_asleep; // [RULE3]
						halt_reg <= 1'b1; // [RULE3]
					end
				cie_ret2: state_reg <= cie_idle; // [RULE5]
				cie_asleep:
					if (wake_s)
					begin
						state_reg <= cie_idle;
						halt_reg <= 1'b0;
					end
			endcase
		end
	end
	assign osc_halt = halt_reg;

	// bus read side
	logic [cie_pkg::ADDR_W-1:0] ra;
	logic [31:0] rmux;
	logic rerr;
	assign ra = {araddr[cie_pkg::ADDR_W-1:2], cie_pkg::WORD_LSB};
	assign arready = !rvalid_reg;

	always_comb
	begin
		rmux = '0;
		rerr = 1'b0;
		unique case (ra)
			cie_pkg::OFF_INSTR: rmux = {30'h0, halt_reg, busy};
			cie_pkg::OFF_ACC: rmux = {24'h0, acc_reg};
			cie_pkg::OFF_FREG: rmux = {24'h0, freg_reg};
			cie_pkg::OFF_STAT: rmux = {27'h0, stat_reg};
			cie_pkg::OFF_STACK: rmux = {8'h0, 8'(sp_reg), 16'(head)};
			cie_pkg::OFF_PC: rmux = {16'h0, 16'(pc_reg)};
			cie_pkg::OFF_WDOG: rmux = {16'h0, wd_pre_reg, wd_cnt_reg};
			default: rerr = 1'b1;
		endcase
	end

	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= cie_pkg::RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rmux;
			rresp_reg <= rerr ? cie_pkg::RESP_SLVERR : cie_pkg::RESP_OKAY;
		end
		else if (rvalid_reg && rready)
			rvalid_reg <= 1'b0;
	end
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_s_n);

	logic go_d;
	cie_pkg::cie_instr_s ins_d;
	always_ff @(posedge clk)
	begin
		go_d <= exec_go;
		ins_d <= ins;
	end

	a_sleep_flags: assert property (exec_go && ins.op == cie_pkg::OP_SLEEP // [RULE1]
		|=> !stat_reg.sleep_entry_flag && stat_reg.expiry_flag)
		else $error("sleep flags wrong");
	a_sleep_wdog: assert property (exec_go && ins.op == cie_pkg::OP_SLEEP // [RULE2]
		|=> wd_cnt_reg == cie_pkg::WDOG_CLR && wd_pre_reg == cie_pkg::WDOG_CLR)
		else $error("watchdog not cleared");
	a_sleep_halt: assert property (exec_go && ins.op == cie_pkg::OP_SLEEP // [RULE3]
		|=> osc_halt throughout (!wake_s [*1]))
		else $error("oscillator not halted");
	a_ret_pop: assert property (exec_go && ins.op == cie_pkg::OP_RET // [RULE4]
		|=> pc_reg == $past(head) && sp_reg == $past(sp_reg) - SP_W'(1) && stat_reg == $past(stat_reg))
		else $error("return pop wrong");
	a_ret_cycles: assert property (exec_go && ins.op == cie_pkg::OP_RET // [RULE5]
		|=> busy ##1 !busy)
		else $error("return not two cycles");
	a_rotate_carry: assert property (exec_go && ins.op == cie_pkg::OP_RROT && ins.dest == cie_pkg::DEST_ACC // [RULE6]
		|=> stat_reg.c == $past(freg_reg[0]) && acc_reg == {$past(stat_reg.c), $past(freg_reg[7:1])}
		&& stat_reg.z == $past(stat_reg.z))
		else $error("rotate wrong");
	a_dest_select: assert property (go_d && ins_d.op == cie_pkg::OP_NSWP // [RULE7]
		|-> (ins_d.dest == cie_pkg::DEST_REG) == (acc_reg == $past(acc_reg) && freg_reg != $past(freg_reg)
		|| $past(freg_reg[3:0]) == $past(freg_reg[7:4]) && ins_d.dest == cie_pkg::DEST_REG))
		else $error("destination wrong");
	a_lit_sub: assert property (exec_go && ins.op == cie_pkg::OP_LSUB // [RULE8]
		|=> acc_reg == 8'($past(ins.lit) - $past(acc_reg)))
		else $error("literal subtract wrong");
	a_reg_sub: assert property (exec_go && ins.op == cie_pkg::OP_RSUB && ins.dest == cie_pkg::DEST_REG // [RULE9]
		|=> freg_reg == 8'($past(freg_reg) - $past(acc_reg)) && acc_reg == $past(acc_reg))
		else $error("register subtract wrong");
	a_swap_flags: assert property (exec_go && ins.op == cie_pkg::OP_NSWP // [RULE10]
		|=> stat_reg == $past(stat_reg))
		else $error("swap touched flags");
	a_xor_zero: assert property (exec_go && (ins.op == cie_pkg::OP_RXOR || ins.op == cie_pkg::OP_LXOR) // [RULE11]
		|=> stat_reg.c == $past(stat_reg.c) && stat_reg.z == ($past(acc_reg) == $past(src))) // [RULE12]
		else $error("xor flags wrong");
	a_sub_borrow: assert property (exec_go && ins.op == cie_pkg::OP_LSUB // [RULE13]
		|=> stat_reg.c == ($past(ins.lit) >= $past(acc_reg))
		&& stat_reg.nibble_out_flag == ($past(ins.lit[3:0]) >= $past(acc_reg[3:0])))
		else $error("borrow sense wrong");
	a_zero_flag: assert property (exec_go && ins.op == cie_pkg::OP_RSUB // [RULE14]
		|=> stat_reg.z == ($past(freg_reg) == $past(acc_reg)))
		else $error("zero flag wrong");

	c_sleep_wake: cover property (exec_go && ins.op == cie_pkg::OP_SLEEP ##[1:50] !osc_halt);
	c_ret_done: cover property (exec_go && ins.op == cie_pkg::OP_RET ##2 !busy);
	c_sub_borrow: cover property (exec_go && ins.op == cie_pkg::OP_RSUB && !diff[8]);
	c_busy_refuse: cover property (bvalid && bresp == cie_pkg::RESP_SLVERR);
endmodule

//--- test/cie_exec_tb.sv
/*
 cie_exec_tb: self-checking bench for the execution slice. It drives the
 register bus itself and uses no partner model.
 assumes: cie_pkg and cie_exec are compiled first; the assertions sit in rtl.
*/
`timescale 1ns/1ns
module cie_exec_tb;
	logic clk, rst_n, wake_pin, osc_halt;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [cie_pkg::ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	int n_errors, n_checks;
	// operand vectors: zero result, digit borrow, sign edge, xor to zero
	logic [7:0] va [4] = '{8'h05, 8'h01, 8'h80, 8'h3c};
	logic [7:0] vf [4] = '{8'h05, 8'h10, 8'h81, 8'hc3};
	logic [7:0] vl [4] = '{8'h05, 8'h00, 8'hff, 8'h3c};
	logic [4:0] vs [4] = '{5'h19, 5'h06, 5'h01, 5'h1e};

	cie_exec cie_exec_inst (.clk(clk), .rst_n(rst_n), .wake_pin(wake_pin), .osc_halt(osc_halt),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp));

	always #2 clk = ~clk;

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// handshakes are judged at the rising edge that takes them; one idle edge after each
	// transfer so that the next call never drives a strobe twice in one step
	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic done;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		wstrb <= 4'hf;
		bready <= 1'b1;
		done = 1'b0;
		resp = 2'h3;
		for (int k = 0; k < 64 && !done; k++)
		begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				done = 1'b1;
				resp = bresp;
				bready <= 1'b0;
			end
		end
		@(posedge clk);
		if (!done)
			n_errors++;
	endtask

	task automatic rd_reg(input logic [4:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic done;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 1'b0;
		d = 32'h0;
		resp = 2'h3;
		for (int k = 0; k < 64 && !done; k++)
		begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				done = 1'b1;
				d = rdata;
				resp = rresp;
				rready <= 1'b0;
			end
		end
		@(posedge clk);
		if (!done)
			n_errors++;
	endtask

	task automatic put(input logic [4:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk_r(r, cie_pkg::RESP_OKAY);
	endtask

	task automatic get_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd_reg(a, d, r);
		chk_d(d & m, e);
		chk_r(r, cie_pkg::RESP_OKAY);
	endtask

	// reference result: {status, operand register, accumulator}
	function automatic logic [20:0] model(input logic [2:0] op, input logic dst, input logic [7:0] lit,
		input logic [7:0] a, input logic [7:0] f, input logic [4:0] st);
		logic [7:0] r, b;
		logic [4:0] s;
		logic to_reg;
		s = st;
		to_reg = dst;
		b = (op == cie_pkg::OP_LSUB || op == cie_pkg::OP_LXOR) ? lit : f;
		case (op)
			cie_pkg::OP_RROT:
			begin
				r = {st[0], f[7:1]};
				s[0] = f[0];
			end
			cie_pkg::OP_LSUB, cie_pkg::OP_RSUB:
			begin
				r = b - a;
				s[0] = b >= a;
				s[1] = b[3:0] >= a[3:0];
				s[2] = r == 8'h00;
			end
			cie_pkg::OP_NSWP:
				r = {f[3:0], f[7:4]};
			default:
			begin
				r = a ^ b;
				s[2] = r == 8'h00;
			end
		endcase
		if (op == cie_pkg::OP_LSUB || op == cie_pkg::OP_LXOR)
			to_reg = 1'b0;
		return to_reg ? {s, r, a} : {s, f, r};
	endfunction

	initial
	begin
		logic [20:0] e;
		clk = 1'b0;
		rst_n = 1'b0;
		wake_pin = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 5'h0;
		araddr = 5'h0;
		wdata = 32'h0;
		wstrb = 4'h0;
		n_errors = 0;
		n_checks = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		get_chk(cie_pkg::OFF_STAT, 32'h1f, {27'h0, cie_pkg::STAT_RST});
		for (int op = 2; op < 8; op++)
			for (int dst = 0; dst < 2; dst++)
				for (int v = 0; v < 4; v++)
				begin
					put(cie_pkg::OFF_ACC, {24'h0, va[v]});
					put(cie_pkg::OFF_FREG, {24'h0, vf[v]});
					put(cie_pkg::OFF_STAT, {27'h0, vs[v]});
					e = model(op[2:0], dst[0], vl[v], va[v], vf[v], vs[v]);
					put(cie_pkg::OFF_INSTR, {20'h0, vl[v], dst[0], op[2:0]});
					get_chk(cie_pkg::OFF_ACC, 32'hff, {24'h0, e[7:0]});
					get_chk(cie_pkg::OFF_FREG, 32'hff, {24'h0, e[15:8]});
					get_chk(cie_pkg::OFF_STAT, 32'h1f, {27'h0, e[20:16]});
				end
		// return pops the head into the pc and leaves flags alone
		put(cie_pkg::OFF_STAT, 32'h15);
		put(cie_pkg::OFF_STACK, 32'h0123);
		put(cie_pkg::OFF_STACK, 32'h1abc);
		put(cie_pkg::OFF_INSTR, {29'h0, cie_pkg::OP_RET});
		get_chk(cie_pkg::OFF_PC, 32'h1fff, 32'h1abc);
		get_chk(cie_pkg::OFF_STACK, 32'h1fff, 32'h0123);
		get_chk(cie_pkg::OFF_STAT, 32'h1f, 32'h15);
		// let the watchdog count so that its clear is visible
		put(cie_pkg::OFF_STAT, 32'h17);
		repeat (600) @(posedge clk);
		rd_reg(cie_pkg::OFF_WDOG, rd, rs);
		chk_d({31'h0, rd[7:0] != 8'h00}, 32'h1);
		put(cie_pkg::OFF_INSTR, {29'h0, cie_pkg::OP_SLEEP});
		chk_d({31'h0, osc_halt}, 32'h1);
		get_chk(cie_pkg::OFF_STAT, 32'h1f, 32'h0f);
		rd_reg(cie_pkg::OFF_WDOG, rd, rs);
		chk_d({31'h0, rd[7:0] == 8'h00 && rd[15:8] < 8'h20}, 32'h1);
		get_chk(cie_pkg::OFF_INSTR, 32'h2, 32'h2);
		wr(cie_pkg::OFF_INSTR, {29'h0, cie_pkg::OP_RROT}, rs);
		chk_r(rs, cie_pkg::RESP_SLVERR);
		wake_pin <= 1'b1;
		for (int k = 0; k < 20 && osc_halt; k++)
			@(negedge clk);
		chk_d({31'h0, osc_halt}, 32'h0);
		@(posedge clk);
		wake_pin <= 1'b0;
		// an unmapped offset is refused both ways
		wr(5'h1c, 32'h0, rs);
		chk_r(rs, cie_pkg::RESP_SLVERR);
		rd_reg(5'h1c, rd, rs);
		chk_r(rs, cie_pkg::RESP_SLVERR);
		tally_and_finish();
	end

	// about ten times the expected run
	initial
	begin
		#90000;
		n_errors++;
		tally_and_finish();
	end
endmodule
